// file: core/snf_consts.svh
// Feature addresses, bit positions, reset values and counts of the feature bank.
`ifndef SNF_CONSTS_SVH
`define SNF_CONSTS_SVH

`define SNF_ADDR_READ_FEAT   8'hB0
`define SNF_ADDR_DRIVE_TIME  8'hD0
`define SNF_ADDR_LOCK_LOAD   8'h60

`define SNF_BIT_OTA_LOCK     7
`define SNF_BIT_OTA_ACCESS   6
`define SNF_BIT_CORR_ON      4
`define SNF_BIT_NORMAL_READ  3
`define SNF_BIT_QUAD_ALLOW   0
`define SNF_BIT_DRIVE_HI     6
`define SNF_BIT_DRIVE_LO     5
`define SNF_BIT_LEARN_ON     3
`define SNF_BIT_DUMMY_EXT    2
`define SNF_BIT_LOCK_DOWN    3
`define SNF_BIT_CONT_ADJ     2
`define SNF_BIT_AUTO_LOAD    1

`define SNF_RST_CORR_ON      1'b1
`define SNF_RST_NORMAL_READ  1'b1
`define SNF_RST_QUAD_ALLOW   1'b1
`define SNF_RST_ZERO_BIT     1'b0
`define SNF_RST_DRIVE        2'h0

`define SNF_CMD_DTR_QUAD_4B  8'hED
`define SNF_CMD_DTR_QUAD     8'hEE
`define SNF_CMD_DUAL_IO      8'hBB
`define SNF_CMD_QUAD_IO      8'hEB

`define SNF_MAIN_BYTES       2048
`define SNF_SPARE_BYTES      128
`define SNF_DUMMY_BASE       8
`define SNF_DUMMY_EXT        10
`define SNF_DUMMY_CONT_ADJ   2

`endif

// file: core/snf_pkg.sv
// Types shared by the feature bank and its cache column walker.
package snf_pkg;
    typedef enum logic {
        SNF_COL_IDLE,
        SNF_COL_STREAM
    } snf_col_state_t;
endpackage

// file: core/snf_cache_column.sv
// Cache column walker that wraps per the selected read mode.
`timescale 1ns/1ps
`include "snf_consts.svh"

module snf_cache_column
    import snf_pkg::*;
#(
    parameter int MAIN_BYTES  = `SNF_MAIN_BYTES,
    parameter int SPARE_BYTES = `SNF_SPARE_BYTES
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [11:0] startCol,
    input  wire logic        advance,
    input  wire logic        abort,
    input  wire logic        normalMode,
    output logic      [11:0] column,
    output logic             nextPage,
    output logic             active
);
    localparam logic [11:0] LastNormal = 12'(MAIN_BYTES + SPARE_BYTES - 1);
    localparam logic [11:0] LastMain   = 12'(MAIN_BYTES - 1);

    snf_col_state_t state;
    snf_col_state_t next_state;
    logic [11:0]    next_column;
    logic           next_nextPage;

    always_comb
    begin
        next_state    = state;
        next_column   = column;
        next_nextPage = 1'b0;
        case (state)
            SNF_COL_IDLE:
            begin
                if (start)
                begin
                    next_state = SNF_COL_STREAM;
                    if (!normalMode)
                        next_column = 12'h0000; // R16
                    else if (startCol > LastNormal)
                        next_column = 12'h0000;
                    else
                        next_column = startCol; // R15
                end
            end
            SNF_COL_STREAM:
            begin
                if (abort)
                    next_state = SNF_COL_IDLE;
                else if (advance)
                begin
                    if (normalMode)
                        next_column = (column == LastNormal) ? 12'h0000 : column + 12'h0001; // R15
                    else if (column == LastMain)
                    begin
                        next_column   = 12'h0000; // R16
                        next_nextPage = 1'b1;
                    end
                    else
                        next_column = column + 12'h0001;
                end
            end
            default: next_state = SNF_COL_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= SNF_COL_IDLE;
            column   <= 12'h0000;
            nextPage <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            column   <= next_column;
            nextPage <= next_nextPage;
        end
    end

    assign active = (state == SNF_COL_STREAM);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_last_normal;
        active && !abort && advance && normalMode && column == LastNormal;
    endsequence

    property p_wrap_normal;
        s_last_normal |=> column == 12'h0000 && !nextPage;
    endproperty
    a_wrap_normal: assert property (p_wrap_normal) else $error("Normal wrap missed."); // R15

    property p_wrap_cont;
        active && !abort && advance && !normalMode && column == LastMain
            |=> column == 12'h0000 && nextPage;
    endproperty
    a_wrap_cont: assert property (p_wrap_cont) else $error("Continuous page step missed."); // R16

    property p_cont_start;
        !active && start && !normalMode |=> active && column == 12'h0000;
    endproperty
    a_cont_start: assert property (p_cont_start) else $error("Continuous start not at zero."); // R16
endmodule // snf_cache_column

// file: core/snf_config_bank.sv
// Volatile configuration feature registers of a serial NAND device.
`timescale 1ns/1ps
`include "snf_consts.svh"

// Behaviour
// [R01] Internal correction runs while bit set; resets 1.
// [R02] Host writes correction bit by feature set.
// [R03] Normal read when 1 (reset), continuous when 0.
// [R04] Host may switch read mode at run time.
// [R05] Quad operations allowed only while quad bit set.
// [R06] Learning pattern only for EDh, EEh when on.
// [R07] Dummy extend alters counts for BBh, EBh only.
// [R08] Drive strength from two bits, both reset 0.
// [R09] Lock-down blocks protection register changes.
// [R10] Lock-down resets 0; software cannot clear it.
// [R11] Continuous-mode dummy adjust matches normal timing.
// [R12] Auto next page load during reads when set; the code requests it in normal read mode only.
// [R13] One-time area access from lock and access bits.
// [R14] Soft reset leaves every bit unchanged.
// [R15] Normal mode streams 2176 bytes, wraps to 0.
// [R16] Continuous mode streams 2048 bytes, next page.
// [R17] Host writes zeros to reserved bits.
// [R18] Host keeps bit 0 of address 60h zero.
// [R19] Dummy counts held as parameters.
module snf_config_bank
    import snf_pkg::*;
#(
    parameter int DUMMY_BASE     = `SNF_DUMMY_BASE,
    parameter int DUMMY_EXT      = `SNF_DUMMY_EXT,
    parameter int DUMMY_CONT_ADJ = `SNF_DUMMY_CONT_ADJ
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        featSet,
    input  wire logic        featGet,
    input  wire logic [7:0]  featAddr,
    input  wire logic [7:0]  featWrData,
    output logic      [7:0]  featRdData,
    output logic             featRdValid,
    input  wire logic        softReset,
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdCode,
    output logic      [4:0]  dummyClocks,
    output logic             learnPatternActive,
    input  wire logic        quadOpReq,
    output logic             quadOpGrant,
    input  wire logic        protWriteReq,
    output logic             protWriteGrant,
    input  wire logic        readStart,
    input  wire logic [11:0] readCol,
    input  wire logic        readAdvance,
    output logic      [11:0] readColumn,
    output logic             readNextPage,
    output logic             readActive,
    output logic             autoLoadRequest,
    output logic             oneTimeAreaOpen,
    output logic             oneTimeAreaWritable,
    output logic             internalCorrectionOn,
    output logic             normalReadSelect,
    output logic             quadIoAllow,
    output logic             learningPatternOn,
    output logic             dummyClockExtend,
    output logic      [1:0]  driveStrength,
    output logic             protectLockDown,
    output logic             contReadDummyAdjust,
    output logic             autoNextPageLoad,
    output logic             oneTimeAreaLock,
    output logic             oneTimeAreaAccess
);
    logic       next_internalCorrectionOn;
    logic       next_normalReadSelect;
    logic       next_quadIoAllow;
    logic       next_learningPatternOn;
    logic       next_dummyClockExtend;
    logic [1:0] next_driveStrength;
    logic       next_protectLockDown;
    logic       next_contReadDummyAdjust;
    logic       next_autoNextPageLoad;
    logic       next_oneTimeAreaLock;
    logic       next_oneTimeAreaAccess;
    logic [7:0] next_featRdData;
    logic       next_featRdValid;
    logic [4:0] next_dummyClocks;
    logic       next_learnPatternActive;
    logic       wrRead;
    logic       wrDrive;
    logic       wrLock;
    logic [7:0] rdMux;
    logic [4:0] dummySel;
    logic       dtrCmd;
    logic       extCmd;

    assign wrRead  = featSet && featAddr == `SNF_ADDR_READ_FEAT;
    assign wrDrive = featSet && featAddr == `SNF_ADDR_DRIVE_TIME;
    assign wrLock  = featSet && featAddr == `SNF_ADDR_LOCK_LOAD;

    // Configuration bits; soft reset deliberately has no path into them.
    always_comb
    begin
        next_internalCorrectionOn = internalCorrectionOn;
        next_normalReadSelect     = normalReadSelect;
        next_quadIoAllow          = quadIoAllow;
        next_oneTimeAreaAccess    = oneTimeAreaAccess;
        next_oneTimeAreaLock      = oneTimeAreaLock;
        next_learningPatternOn    = learningPatternOn;
        next_dummyClockExtend     = dummyClockExtend;
        next_driveStrength        = driveStrength;
        next_protectLockDown      = protectLockDown;
        next_contReadDummyAdjust  = contReadDummyAdjust;
        next_autoNextPageLoad     = autoNextPageLoad;
        if (wrRead)
        begin
            next_internalCorrectionOn = featWrData[`SNF_BIT_CORR_ON]; // R02
            next_normalReadSelect     = featWrData[`SNF_BIT_NORMAL_READ]; // R04
            next_quadIoAllow          = featWrData[`SNF_BIT_QUAD_ALLOW];
            next_oneTimeAreaAccess    = featWrData[`SNF_BIT_OTA_ACCESS];
            // The lock bit only programs while the area is open, and never unprograms.
            if (oneTimeAreaAccess && featWrData[`SNF_BIT_OTA_LOCK])
                next_oneTimeAreaLock = 1'b1; // R13
        end
        if (wrDrive)
        begin
            next_learningPatternOn = featWrData[`SNF_BIT_LEARN_ON];
            next_dummyClockExtend  = featWrData[`SNF_BIT_DUMMY_EXT];
            next_driveStrength     = {featWrData[`SNF_BIT_DRIVE_HI],
                                      featWrData[`SNF_BIT_DRIVE_LO]}; // R08
        end
        if (wrLock)
        begin
            // Writing 0 cannot clear the lock-down; only power-on reset does.
            next_protectLockDown     = protectLockDown | featWrData[`SNF_BIT_LOCK_DOWN]; // R10
            next_contReadDummyAdjust = featWrData[`SNF_BIT_CONT_ADJ];
            next_autoNextPageLoad    = featWrData[`SNF_BIT_AUTO_LOAD];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            internalCorrectionOn <= `SNF_RST_CORR_ON; // R01
            normalReadSelect     <= `SNF_RST_NORMAL_READ; // R03
            quadIoAllow          <= `SNF_RST_QUAD_ALLOW;
            oneTimeAreaAccess    <= `SNF_RST_ZERO_BIT;
            oneTimeAreaLock      <= `SNF_RST_ZERO_BIT;
            learningPatternOn    <= `SNF_RST_ZERO_BIT;
            dummyClockExtend     <= `SNF_RST_ZERO_BIT;
            driveStrength        <= `SNF_RST_DRIVE;
            protectLockDown      <= `SNF_RST_ZERO_BIT; // R10
            contReadDummyAdjust  <= `SNF_RST_ZERO_BIT;
            autoNextPageLoad     <= `SNF_RST_ZERO_BIT;
        end
        else
        begin
            internalCorrectionOn <= next_internalCorrectionOn;
            normalReadSelect     <= next_normalReadSelect;
            quadIoAllow          <= next_quadIoAllow;
            oneTimeAreaAccess    <= next_oneTimeAreaAccess;
            oneTimeAreaLock      <= next_oneTimeAreaLock;
            learningPatternOn    <= next_learningPatternOn;
            dummyClockExtend     <= next_dummyClockExtend;
            driveStrength        <= next_driveStrength;
            protectLockDown      <= next_protectLockDown;
            contReadDummyAdjust  <= next_contReadDummyAdjust;
            autoNextPageLoad     <= next_autoNextPageLoad;
        end
    end

    // Read-back: undefined and reserved positions, including bit 0 of 60h, read zero.
    always_comb
    begin
        rdMux = 8'h00; // R17
        case (featAddr)
            `SNF_ADDR_READ_FEAT:
            begin
                rdMux[`SNF_BIT_OTA_LOCK]    = oneTimeAreaLock;
                rdMux[`SNF_BIT_OTA_ACCESS]  = oneTimeAreaAccess;
                rdMux[`SNF_BIT_CORR_ON]     = internalCorrectionOn;
                rdMux[`SNF_BIT_NORMAL_READ] = normalReadSelect;
                rdMux[`SNF_BIT_QUAD_ALLOW]  = quadIoAllow;
            end
            `SNF_ADDR_DRIVE_TIME:
            begin
                rdMux[`SNF_BIT_DRIVE_HI]  = driveStrength[1];
                rdMux[`SNF_BIT_DRIVE_LO]  = driveStrength[0];
                rdMux[`SNF_BIT_LEARN_ON]  = learningPatternOn;
                rdMux[`SNF_BIT_DUMMY_EXT] = dummyClockExtend;
            end
            `SNF_ADDR_LOCK_LOAD:
            begin
                rdMux[`SNF_BIT_LOCK_DOWN] = protectLockDown;
                rdMux[`SNF_BIT_CONT_ADJ]  = contReadDummyAdjust;
                rdMux[`SNF_BIT_AUTO_LOAD] = autoNextPageLoad; // R18
            end
            default: rdMux = 8'h00;
        endcase
    end

    // Per-command decisions are latched when a read command is decoded.
    always_comb
    begin
        dtrCmd   = cmdCode == `SNF_CMD_DTR_QUAD_4B || cmdCode == `SNF_CMD_DTR_QUAD;
        extCmd   = cmdCode == `SNF_CMD_DUAL_IO || cmdCode == `SNF_CMD_QUAD_IO;
        dummySel = (extCmd && dummyClockExtend) ? 5'(DUMMY_EXT) : 5'(DUMMY_BASE); // R07 R19
        if (!normalReadSelect && contReadDummyAdjust)
            dummySel = dummySel + 5'(DUMMY_CONT_ADJ); // R11
        next_featRdData         = featGet ? rdMux : featRdData;
        next_featRdValid        = featGet;
        next_dummyClocks        = cmdValid ? dummySel : dummyClocks;
        next_learnPatternActive = cmdValid ? (dtrCmd && learningPatternOn) // R06
                                           : learnPatternActive;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            featRdData         <= 8'h00;
            featRdValid        <= 1'b0;
            dummyClocks        <= 5'(DUMMY_BASE);
            learnPatternActive <= 1'b0;
        end
        else
        begin
            featRdData         <= next_featRdData;
            featRdValid        <= next_featRdValid;
            dummyClocks        <= next_dummyClocks;
            learnPatternActive <= next_learnPatternActive;
        end
    end

    assign quadOpGrant         = quadOpReq && quadIoAllow; // R05
    assign protWriteGrant      = protWriteReq && !protectLockDown; // R09
    assign oneTimeAreaOpen     = oneTimeAreaAccess; // R13
    assign oneTimeAreaWritable = oneTimeAreaAccess && !oneTimeAreaLock; // R13
    // Automatic loading is offered only in normal read mode.
    assign autoLoadRequest     = autoNextPageLoad && normalReadSelect && readActive; // R12

    snf_cache_column u_column (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (readStart),
        .startCol   (readCol),
        .advance    (readAdvance),
        .abort      (softReset), // R14
        .normalMode (normalReadSelect), // R03
        .column     (readColumn),
        .nextPage   (readNextPage),
        .active     (readActive)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_write_read;
        wrRead;
    endsequence

    sequence s_write_lock;
        wrLock;
    endsequence

    property p_corr_write;
        s_write_read |=> internalCorrectionOn == $past(featWrData[`SNF_BIT_CORR_ON]);
    endproperty
    a_corr_write: assert property (p_corr_write) else $error("Correction bit not written."); // R02

    property p_mode_write;
        s_write_read |=> normalReadSelect == $past(featWrData[`SNF_BIT_NORMAL_READ]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("Read mode not written."); // R04

    property p_lock_sticky;
        protectLockDown |=> protectLockDown;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("Lock-down cleared."); // R10

    property p_lock_set;
        s_write_lock ##0 featWrData[`SNF_BIT_LOCK_DOWN] |=> protectLockDown [*2];
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("Lock-down not set."); // R09

    property p_prot_block;
        s_write_lock ##0 featWrData[`SNF_BIT_LOCK_DOWN] ##1 protWriteReq |-> !protWriteGrant;
    endproperty
    a_prot_block: assert property (p_prot_block) else $error("Protection write passed."); // R09

    property p_quad;
        s_write_read ##0 !featWrData[`SNF_BIT_QUAD_ALLOW] |=> !quadOpGrant;
    endproperty
    a_quad: assert property (p_quad) else $error("Quad op granted while off."); // R05

    property p_learn;
        cmdValid && !dtrCmd |=> !learnPatternActive;
    endproperty
    a_learn: assert property (p_learn) else $error("Pattern on wrong command."); // R06

    property p_dummy_ext;
        cmdValid && extCmd && dummyClockExtend && normalReadSelect
            |=> dummyClocks == 5'(DUMMY_EXT);
    endproperty
    a_dummy_ext: assert property (p_dummy_ext) else $error("Extended dummy count wrong."); // R07

    property p_drive;
        wrDrive |=> driveStrength == $past(featWrData[6:5]);
    endproperty
    a_drive: assert property (p_drive) else $error("Drive strength not written."); // R08

    property p_soft_keep;
        softReset && !featSet |=> $stable(internalCorrectionOn) && $stable(normalReadSelect)
            && $stable(driveStrength) && $stable(protectLockDown) && $stable(autoNextPageLoad);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("Soft reset changed config."); // R14

    property p_read_back;
        featGet && featAddr == `SNF_ADDR_LOCK_LOAD |=> featRdValid && !featRdData[0];
    endproperty
    a_read_back: assert property (p_read_back) else $error("Reserved bit read nonzero."); // R18
endmodule // snf_config_bank

// file: tb/snf_host_model.sv
// Host controller model that issues set-feature and get-feature transfers.
`timescale 1ns/1ps
`include "snf_consts.svh"

module snf_host_model
(
    input  wire logic       clk,
    output logic            featSet,
    output logic            featGet,
    output logic      [7:0] featAddr,
    output logic      [7:0] featWrData,
    input  wire logic [7:0] featRdData,
    input  wire logic       featRdValid
);
    initial
    begin
        featSet    = 1'b0;
        featGet    = 1'b0;
        featAddr   = 8'h00;
        featWrData = 8'h00;
    end

    // Idle address and data lines show the inverse of the last value, never a stale copy.
    task automatic set_feat(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] keep;
        keep = (addr == `SNF_ADDR_READ_FEAT) ? 8'hD9 :
               (addr == `SNF_ADDR_DRIVE_TIME) ? 8'h6C : 8'h0E;
        @(posedge clk);
        featSet    <= 1'b1;
        featAddr   <= addr;
        featWrData <= data & keep;
        @(posedge clk);
        featSet    <= 1'b0;
        featAddr   <= ~addr;
        featWrData <= ~(data & keep);
    endtask

    task automatic get_feat(input logic [7:0] addr, output logic [7:0] data, output bit ok);
        ok   = 1'b0;
        data = 8'h00;
        @(posedge clk);
        featGet  <= 1'b1;
        featAddr <= addr;
        @(posedge clk);
        featGet  <= 1'b0;
        featAddr <= ~addr;
        repeat (4)
        begin
            @(posedge clk);
            if (!ok && featRdValid === 1'b1)
            begin
                data = featRdData;
                ok   = 1'b1;
            end
        end
    endtask
endmodule // snf_host_model

// file: tb/test_serial_nand_feature_config_bank.sv
// Self-checking bench for the feature bank driven through a host controller model.
`timescale 1ns/1ps
`include "snf_consts.svh"

module test_serial_nand_feature_config_bank
    import snf_pkg::*;
;
    typedef struct packed {logic [7:0] addr; logic [7:0] wr; logic [7:0] exp;} snf_row_t;

    logic        clk, rst_n, featSet, featGet, featRdValid, softReset, cmdValid;
    logic        learnPatternActive, quadOpReq, quadOpGrant, protWriteReq, protWriteGrant;
    logic        readStart, readAdvance, readNextPage, readActive, autoLoadRequest;
    logic        oneTimeAreaOpen, oneTimeAreaWritable, internalCorrectionOn, normalReadSelect;
    logic        quadIoAllow, learningPatternOn, dummyClockExtend, protectLockDown;
    logic        contReadDummyAdjust, autoNextPageLoad, oneTimeAreaLock, oneTimeAreaAccess;
    logic [7:0]  featAddr, featWrData, featRdData, cmdCode, rd;
    logic [4:0]  dummyClocks;
    logic [1:0]  driveStrength;
    logic [11:0] readCol, readColumn;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          expDummy;
    bit          ok, ext, expLearn;
    logic [7:0]  codes [5] = '{8'hBB, 8'hEB, 8'hED, 8'hEE, 8'h03};
    snf_row_t    rows [9] = '{'{8'hB0, 8'h00, 8'h00}, '{8'hB0, 8'hFF, 8'h59},
        '{8'hB0, 8'hFF, 8'hD9}, '{8'hB0, 8'h19, 8'h99}, '{8'hD0, 8'hFF, 8'h6C},
        '{8'hD0, 8'h40, 8'h40}, '{8'h60, 8'hFF, 8'h0E}, '{8'h60, 8'h00, 8'h08},
        '{8'h55, 8'hFF, 8'h00}};

    snf_config_bank uut
    (
        .clk, .rst_n, .featSet, .featGet, .featAddr, .featWrData, .featRdData, .featRdValid,
        .softReset, .cmdValid, .cmdCode, .dummyClocks, .learnPatternActive, .quadOpReq,
        .quadOpGrant, .protWriteReq, .protWriteGrant, .readStart, .readCol, .readAdvance,
        .readColumn, .readNextPage, .readActive, .autoLoadRequest, .oneTimeAreaOpen,
        .oneTimeAreaWritable, .internalCorrectionOn, .normalReadSelect, .quadIoAllow,
        .learningPatternOn, .dummyClockExtend, .driveStrength, .protectLockDown,
        .contReadDummyAdjust, .autoNextPageLoad, .oneTimeAreaLock, .oneTimeAreaAccess
    );

    snf_host_model host
    (
        .clk, .featSet, .featGet, .featAddr, .featWrData, .featRdData, .featRdValid
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        host.get_feat(addr, rd, ok);
        if (!ok)
        begin
            num_errors++;
            $display("mismatch at %0t: read of %h got no answer", $time, addr);
            end_sim();
        end
        chk({4'h0, rd}, {4'h0, exp}, "feature read");
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic cmd(input logic [7:0] code);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdCode  <= code;
        @(posedge clk);
        cmdValid <= 1'b0;
        #1;
    endtask

    task automatic start(input logic [11:0] col);
        @(posedge clk);
        readStart <= 1'b1;
        readCol   <= col;
        @(posedge clk);
        readStart <= 1'b0;
        #1;
    endtask

    task automatic adv(input int n);
        @(posedge clk);
        readAdvance <= 1'b1;
        repeat (n) @(posedge clk);
        readAdvance <= 1'b0;
        #1;
    endtask

    task automatic soft_reset();
        @(posedge clk);
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        #1;
    endtask

    initial
    begin
        rst_n        = 1'b0;
        softReset    = 1'b0;
        cmdValid     = 1'b0;
        cmdCode      = 8'h00;
        quadOpReq    = 1'b1;
        protWriteReq = 1'b1;
        readStart    = 1'b0;
        readCol      = 12'h000;
        readAdvance  = 1'b0;
        do_reset();
        foreach (rows[i])
        begin
            host.set_feat(rows[i].addr, rows[i].wr);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        #1;
        chk({11'h000, protWriteGrant}, 12'h000, "protect write grant");
        chk({10'h000, driveStrength}, 12'h002, "drive strength");
        chk({9'h000, oneTimeAreaOpen, oneTimeAreaWritable, oneTimeAreaLock}, 12'h001, "otp");
        $display("register rows done");
        host.set_feat(`SNF_ADDR_LOCK_LOAD, 8'h04);
        for (int p = 0; p < 3; p++)
        begin
            host.set_feat(`SNF_ADDR_DRIVE_TIME, (p == 2) ? 8'h00 : 8'h0C);
            host.set_feat(`SNF_ADDR_READ_FEAT, (p == 1) ? 8'h19 : 8'h11);
            chk({7'h00, oneTimeAreaAccess, learningPatternOn, dummyClockExtend,
                contReadDummyAdjust, autoNextPageLoad}, {7'h00, 1'b0, (p != 2), (p != 2), 2'b10},
                "config outputs");
            foreach (codes[k])
            begin
                cmd(codes[k]);
                ext = p != 2 && (codes[k] == `SNF_CMD_DUAL_IO || codes[k] == `SNF_CMD_QUAD_IO);
                expLearn = p != 2 && (codes[k] == `SNF_CMD_DTR_QUAD_4B ||
                    codes[k] == `SNF_CMD_DTR_QUAD);
                expDummy = (ext ? `SNF_DUMMY_EXT : `SNF_DUMMY_BASE) +
                    ((p != 1) ? `SNF_DUMMY_CONT_ADJ : 0);
                chk({7'h00, dummyClocks}, 12'(expDummy), "dummy clocks");
                chk({11'h000, learnPatternActive}, {11'h000, expLearn}, "pattern");
            end
        end
        $display("command decode done");
        host.set_feat(`SNF_ADDR_READ_FEAT, 8'h10);
        #1;
        chk({11'h000, quadOpGrant}, 12'h000, "quad grant refused");
        start(12'h123);
        chk({11'h000, readActive}, 12'h001, "continuous active");
        chk(readColumn, 12'h000, "continuous start");
        adv(2047);
        chk({11'h000, readNextPage}, 12'h000, "no early page step");
        chk(readColumn, 12'h7FF, "last main byte");
        adv(1);
        chk({11'h000, readNextPage}, 12'h001, "page step");
        chk(readColumn, 12'h000, "next page");
        soft_reset();
        chk({11'h000, readActive}, 12'h000, "soft reset ends walk");
        rd_chk(`SNF_ADDR_READ_FEAT, 8'h90);
        rd_chk(`SNF_ADDR_LOCK_LOAD, 8'h0C);
        $display("continuous walk done");
        host.set_feat(`SNF_ADDR_LOCK_LOAD, 8'h02);
        host.set_feat(`SNF_ADDR_READ_FEAT, 8'h18);
        start(12'h87E);
        chk({11'h000, autoLoadRequest}, 12'h001, "auto load request");
        chk(readColumn, 12'h87E, "normal start");
        adv(1);
        chk({11'h000, readColumn[0]}, 12'h001, "normal last byte");
        chk(readColumn, 12'h87F, "normal last column");
        adv(1);
        chk({11'h000, readNextPage}, 12'h000, "no page step in normal");
        chk(readColumn, 12'h000, "normal wrap");
        $display("normal walk done");
        do_reset();
        #1;
        chk({5'h00, internalCorrectionOn, normalReadSelect, quadIoAllow, protectLockDown,
            readActive, protWriteGrant, quadOpGrant}, 12'h073, "reset values");
        chk({7'h00, dummyClocks}, 12'(`SNF_DUMMY_BASE), "reset dummy");
        rd_chk(`SNF_ADDR_READ_FEAT, 8'h19);
        rd_chk(`SNF_ADDR_DRIVE_TIME, 8'h00);
        rd_chk(`SNF_ADDR_LOCK_LOAD, 8'h00);
        start(12'hFFF);
        chk(readColumn, 12'h000, "start past end");
        $display("second reset done");
        end_sim();
    end
endmodule // test_serial_nand_feature_config_bank
